// ==== inc/hbsgc_pkg.sv ====
// Contract
// - After reset the bypass-passive bit is 1 and every bridge mode is 00.
// - Committing a bypass-passive bit of 0 enters active bridge driving.
// - Enable high plus bypass 0 or any mode 01/10 is active; else passive.
// - Active driving needs no supply, pump or temperature fault and no fail-safe.
// - Mode 00 and 11 hold both off, 01 low side on, 10 high side on.
// - Static switch-on only for bridges not mapped to an enabled PWM channel.
// - A 4-bit static code per bridge selects one of sixteen current steps.
// - Hard-off current is discharge code 31, holding a switch off while opposite turns on.
// - Hold select 0 gives the 12.5/14.2 mA step, 1 gives 23.9/26.0 mA.
// - Listed faults in active mode turn switches off with static discharge current.
// - Mode 01 to 10 first discharges both with static current for cross-conduction time.
// - Then high side charges statically, low side hard-off, for blank plus filter time.
// - After filter time the drives drop to positive and negative hold currents.
// - Mode 00 to 10 skips cross-conduction and starts at the chip-select rise.
// - Chip-select rise is resynchronised and the command runs within 3 us.
// - Low-side turn-on follows the same phases with the sides exchanged.
// - Mode 00 or 11 discharges both statically for cross-conduction time, then hold.
`default_nettype none
package hbsgc_pkg;
   localparam int          NUM_HB          = 8;
   localparam int          TIME_W          = 8;
   localparam logic [1:0]  MODE_OFF        = 2'h0;
   localparam logic [1:0]  MODE_LS_ON      = 2'h1;
   localparam logic [1:0]  MODE_HS_ON      = 2'h2;
   localparam logic        BYPASS_RESET    = 1'h1;
   localparam logic        HOLD_SEL_RESET  = 1'h0;
   localparam logic [4:0]  HARD_OFF_CODE   = 5'h1F;
   localparam logic [4:0]  HOLD_LOW_CODE   = 5'h04;
   localparam logic [4:0]  HOLD_HIGH_CODE  = 5'h06;
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          EXEC_MAX_NS     = 3;
   localparam int          EXEC_MAX_NS_UNIT = 1000;
   // Longest time, so the cycle count rounds down.
   localparam int          EXEC_MAX_CYC    = (EXEC_MAX_NS * EXEC_MAX_NS_UNIT * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      CUR_STATIC   = 2'b00,
      CUR_HOLD     = 2'b01,
      CUR_HARD_OFF = 2'b10
   } hbsgc_src_type;

   typedef enum logic [5:0] {
      ST_OFF     = 6'b000001,
      ST_CCP_ON  = 6'b000010,
      ST_BLANK   = 6'b000100,
      ST_ON      = 6'b001000,
      ST_CCP_OFF = 6'b010000,
      ST_FAULT   = 6'b100000
   } hbsgc_state_type;

   typedef struct packed {
      logic          drive;
      logic          charge;
      hbsgc_src_type src;
      logic [4:0]    code;
   } hbsgc_gate_type;

   typedef struct packed {
      logic vs_ov;
      logic vs_uv;
      logic cp_uv;
      logic over_temp;
      logic fail_safe;
      logic vds_ov;
      logic over_current;
   } hbsgc_fault_type;

   typedef struct packed {
      logic                    bridge_bypass_passive;
      logic                    hold_current_select;
      logic [2*NUM_HB-1:0]     half_bridge_mode;
   } hbsgc_cmd_type;
endpackage : hbsgc_pkg
`default_nettype wire

// ==== rtl/hbsgc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Phase sequencer of one half-bridge.
module hbsgc_bridge_seq
   import hbsgc_pkg::*;
(
   // Clock and reset.
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   // Command and conditions.
   input  wire logic              exec_i,
   input  wire logic [1:0]        mode_i,
   input  wire logic              mapped_i,
   input  wire logic              fault_i,
   input  wire logic              en_i,
   input  wire logic              hold_sel_i,
   // Per-bridge configuration.
   input  wire logic [3:0]        static_code_i,
   input  wire logic [TIME_W-1:0] ccp_time_i,
   input  wire logic [TIME_W-1:0] blank_time_i,
   input  wire logic [TIME_W-1:0] filter_time_i,
   // Gate drives.
   output hbsgc_gate_type         hs_o,
   output hbsgc_gate_type         ls_o
);
   hbsgc_state_type   state;
   hbsgc_state_type   next_state;
   logic [TIME_W:0]   timer;
   logic [TIME_W:0]   next_timer;
   logic              side_hs;
   logic              next_side_hs;
   hbsgc_gate_type    next_hs;
   hbsgc_gate_type    next_ls;
   hbsgc_gate_type    g_stat_dis;
   hbsgc_gate_type    g_stat_chg;
   hbsgc_gate_type    g_hard;
   hbsgc_gate_type    g_hold_on;
   hbsgc_gate_type    g_hold_off;

   // Phase lengths; a count of N gives N cycles, never less than one.
   wire logic [TIME_W:0] ccp_load   = (ccp_time_i == '0) ? '0 : {1'b0, ccp_time_i} - 1'b1;
   wire logic [TIME_W:0] bf_sum     = {1'b0, blank_time_i} + {1'b0, filter_time_i};
   wire logic [TIME_W:0] bf_load    = (bf_sum == '0) ? '0 : bf_sum - 1'b1;
   wire logic            on_req     = (mode_i == MODE_LS_ON || mode_i == MODE_HS_ON) && !mapped_i;
   wire logic            req_hs     = (mode_i == MODE_HS_ON);
   wire logic            was_on     = (state == ST_CCP_ON) || (state == ST_BLANK) || (state == ST_ON);
   wire logic [4:0]      hold_code  = hold_sel_i ? HOLD_HIGH_CODE : HOLD_LOW_CODE;

   // Drive templates for each current source.
   assign g_stat_dis = '{drive: en_i, charge: 1'b0, src: CUR_STATIC, code: {1'b0, static_code_i}};
   assign g_stat_chg = '{drive: en_i, charge: 1'b1, src: CUR_STATIC, code: {1'b0, static_code_i}};
   assign g_hard     = '{drive: en_i, charge: 1'b0, src: CUR_HARD_OFF, code: HARD_OFF_CODE};
   assign g_hold_on  = '{drive: en_i, charge: 1'b1, src: CUR_HOLD, code: hold_code};
   assign g_hold_off = '{drive: en_i, charge: 1'b0, src: CUR_HOLD, code: hold_code};

   // Next phase; a fault outranks any command or running phase.
   always_comb
   begin
      next_state   = state;
      next_timer   = timer;
      next_side_hs = side_hs;
      if (fault_i)
      begin
         next_state = ST_FAULT;
         next_timer = '0;
      end
      else if (exec_i && on_req)
      begin
         next_side_hs = req_hs;
         if (was_on && req_hs != side_hs)
         begin
            next_state = ST_CCP_ON;
            next_timer = ccp_load;
         end
         else if (!(was_on && req_hs == side_hs))
         begin
            next_state = ST_BLANK;
            next_timer = bf_load;
         end
      end
      else if (exec_i)
      begin
         next_state = ST_CCP_OFF;
         next_timer = ccp_load;
      end
      else if (timer != '0)
      begin
         next_timer = timer - 1'b1;
      end
      else
      begin
         case (state)
            ST_CCP_ON:
            begin
               next_state = ST_BLANK;
               next_timer = bf_load;
            end
            ST_BLANK:   next_state = ST_ON;
            ST_CCP_OFF: next_state = ST_OFF;
            default:    next_state = state;
         endcase
      end
   end

   // Drive currents for the next phase, steered by which side turns on.
   always_comb
   begin
      case (next_state)
         ST_BLANK:
         begin
            next_hs = next_side_hs ? g_stat_chg : g_hard;
            next_ls = next_side_hs ? g_hard : g_stat_chg;
         end
         ST_ON:
         begin
            next_hs = next_side_hs ? g_hold_on : g_hold_off;
            next_ls = next_side_hs ? g_hold_off : g_hold_on;
         end
         ST_OFF:
         begin
            next_hs = g_hold_off;
            next_ls = g_hold_off;
         end
         default:
         begin
            next_hs = g_stat_dis;
            next_ls = g_stat_dis;
         end
      endcase
   end

   // State, timer and registered drives.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state   <= ST_OFF;
         timer   <= '0;
         side_hs <= 1'b0;
         hs_o    <= '0;
         ls_o    <= '0;
      end
      else
      begin
         state   <= next_state;
         timer   <= next_timer;
         side_hs <= next_side_hs;
         hs_o    <= next_hs;
         ls_o    <= next_ls;
      end
   end
endmodule : hbsgc_bridge_seq

// Static gate control of eight half-bridges.
module hbsgc_top
   import hbsgc_pkg::*;
(
   // Clock and reset.
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   // Device pins.
   input  wire logic                     enable_i,
   input  wire logic                     cs_n_i,
   // Decoded command from the serial frame.
   input  wire logic                     cmd_wr_i,
   input  wire hbsgc_cmd_type            cmd_i,
   // Fault flags and configuration.
   input  wire hbsgc_fault_type          faults_i,
   input  wire logic                     overcurrent_shutdown_enable_i,
   input  wire logic [NUM_HB-1:0]        pwm_mapped_i,
   input  wire logic [4*NUM_HB-1:0]      static_gate_current_code_i,
   input  wire logic [TIME_W*NUM_HB-1:0] cross_conduction_time_i,
   input  wire logic [TIME_W*NUM_HB-1:0] drain_source_blank_time_i,
   input  wire logic [TIME_W-1:0]        drain_source_filter_time_i,
   // Gate drives and status.
   output hbsgc_gate_type [NUM_HB-1:0]   high_side_o,
   output hbsgc_gate_type [NUM_HB-1:0]   low_side_o,
   output logic                          drivers_active_o,
   output logic                          bridge_bypass_passive_o,
   output logic [2*NUM_HB-1:0]           half_bridge_mode_o,
   output logic                          exec_o
);
   localparam int AST_EXEC_MAX = EXEC_MAX_CYC;

   hbsgc_cmd_type shadow;
   logic          pending;
   logic          cs_meta;
   logic          cs_sync;
   logic          cs_prev;
   logic          hold_sel;

   // Chip-select rise, seen only after the two-stage synchroniser.
   wire logic cs_rise  = cs_sync && !cs_prev;
   wire logic commit   = cs_rise && pending;
   wire logic any_on;
   wire logic sup_flt  = faults_i.vs_ov || faults_i.vs_uv || faults_i.cp_uv || faults_i.over_temp;
   wire logic shutdown = sup_flt || faults_i.vds_ov || (faults_i.over_current && overcurrent_shutdown_enable_i);
   wire logic req_act  = enable_i && (!bridge_bypass_passive_o || any_on) && !faults_i.fail_safe;
   wire logic grant    = req_act && !sup_flt;

   // Any bridge asking for a switch to be on keeps the driver active.
   logic [NUM_HB-1:0] on_vec;
   for (genvar i = 0; i < NUM_HB; i++)
   begin : g_on
      assign on_vec[i] = (half_bridge_mode_o[2*i +: 2] == MODE_LS_ON) || (half_bridge_mode_o[2*i +: 2] == MODE_HS_ON);
   end
   assign any_on = |on_vec;

   // Command capture and commit; a write in the commit cycle stays pending.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cs_meta                 <= 1'b1;
         cs_sync                 <= 1'b1;
         cs_prev                 <= 1'b1;
         pending                 <= 1'b0;
         shadow                  <= '0;
         bridge_bypass_passive_o <= BYPASS_RESET;
         half_bridge_mode_o      <= '0;
         hold_sel                <= HOLD_SEL_RESET;
         exec_o                  <= 1'b0;
      end
      else
      begin
         cs_meta <= cs_n_i;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         pending <= cmd_wr_i || (pending && !commit);
         exec_o  <= commit;
         if (cmd_wr_i)
            shadow <= cmd_i;
         if (commit)
         begin
            bridge_bypass_passive_o <= shadow.bridge_bypass_passive;
            half_bridge_mode_o      <= shadow.half_bridge_mode;
            hold_sel                <= shadow.hold_current_select;
         end
      end
   end

   // Registered grant; the gate drive itself stays on during a shutdown so the gates discharge.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         drivers_active_o <= 1'b0;
      end
      else
      begin
         drivers_active_o <= grant;
      end
   end

   // One independent sequencer per bridge.
   for (genvar i = 0; i < NUM_HB; i++)
   begin : g_hb
      hbsgc_bridge_seq u_seq (
         .core_clk_i    (core_clk_i),
         .rst_i         (rst_i),
         .exec_i        (exec_o),
         .mode_i        (half_bridge_mode_o[2*i +: 2]),
         .mapped_i      (pwm_mapped_i[i]),
         .fault_i       (shutdown && req_act),
         .en_i          (req_act),
         .hold_sel_i    (hold_sel),
         .static_code_i (static_gate_current_code_i[4*i +: 4]),
         .ccp_time_i    (cross_conduction_time_i[TIME_W*i +: TIME_W]),
         .blank_time_i  (drain_source_blank_time_i[TIME_W*i +: TIME_W]),
         .filter_time_i (drain_source_filter_time_i),
         .hs_o          (high_side_o[i]),
         .ls_o          (low_side_o[i])
      );
   end

   // Checks on bridge 0 stand for all, since every bridge is the same sequencer.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   AST_RESET_PASSIVE: assert property ($fell(rst_i) |-> bridge_bypass_passive_o && half_bridge_mode_o == '0)
      else $error("Reset did not leave the bridge passive.");
   AST_BYPASS_CLEAR: assert property (commit && !shadow.bridge_bypass_passive |=> !bridge_bypass_passive_o)
      else $error("Bypass-passive clear was not taken.");
   AST_PASSIVE_NO_EN: assert property (!enable_i |=> !drivers_active_o)
      else $error("Drivers active with enable low.");
   AST_GRANT_FAULT: assert property (sup_flt || faults_i.fail_safe |=> !drivers_active_o)
      else $error("Active drive granted during a fault.");
   AST_EXCLUSIVE: assert property (!(high_side_o[0].charge && low_side_o[0].charge))
      else $error("Both switches of a bridge are charged.");
   AST_HARD_OFF: assert property (high_side_o[0].charge && high_side_o[0].src == CUR_STATIC
      |-> low_side_o[0].src == CUR_HARD_OFF && low_side_o[0].code == HARD_OFF_CODE)
      else $error("Opposite switch not held hard off.");
   AST_HOLD_LEVEL: assert property (high_side_o[0].src == CUR_HOLD
      |-> high_side_o[0].code == ($past(hold_sel) ? HOLD_HIGH_CODE : HOLD_LOW_CODE))
      else $error("Hold current step does not match the select bit.");
   AST_SHUTDOWN: assert property (shutdown && req_act
      |=> high_side_o[0].src == CUR_STATIC && !high_side_o[0].charge && !low_side_o[0].charge)
      else $error("Fault did not discharge with static current.");
   AST_CCP_GAP: assert property (low_side_o[0].charge |=> !high_side_o[0].charge)
      else $error("High side charged straight after low side.");
   AST_EXEC_DELAY: assert property ($rose(cs_n_i) && pending |-> ##[1:AST_EXEC_MAX] exec_o)
      else $error("Command not executed within the allowed delay.");

   COV_EXEC: cover property (exec_o);
   COV_HS_BLANK: cover property (high_side_o[0].charge && low_side_o[0].src == CUR_HARD_OFF);
   COV_SWAP: cover property (low_side_o[0].charge ##[1:300] high_side_o[0].charge);
   COV_SHUTDOWN: cover property (shutdown && req_act);
endmodule : hbsgc_top
`default_nettype wire

// ==== testbench/hbsgc_fet_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// External MOSFET pair per bridge: a coarse gate level that charges and discharges.
module hbsgc_fet_model
   import hbsgc_pkg::*;
(
   // Clock and reset.
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_i,
   // Gate drives from the device.
   input  wire hbsgc_gate_type [NUM_HB-1:0] high_side_i,
   input  wire hbsgc_gate_type [NUM_HB-1:0] low_side_i,
   // Switch states.
   output logic [NUM_HB-1:0]           hs_on_o,
   output logic                        shoot_o
);
   logic [3:0] hs_v [NUM_HB];
   logic [3:0] ls_v [NUM_HB];
   logic [NUM_HB-1:0] ls_on;

   // Hard-off sinks faster than the static step, so it pulls the gate down harder.
   function automatic logic [3:0] step(input logic [3:0] v, input hbsgc_gate_type g);
      if (g.drive && g.charge)
         step = (v == 4'hF) ? v : v + 4'h1;
      else if (g.src == CUR_HARD_OFF)
         step = (v < 4'h4) ? 4'h0 : v - 4'h4;
      else
         step = (v == 4'h0) ? v : v - 4'h1;
   endfunction : step

   // A passive gate leaks towards off; a shoot-through is latched until reset.
   always_ff @(posedge core_clk_i)
   begin
      for (int i = 0; i < NUM_HB; i++)
      begin
         hs_v[i] <= rst_i ? 4'h0 : step(hs_v[i], high_side_i[i]);
         ls_v[i] <= rst_i ? 4'h0 : step(ls_v[i], low_side_i[i]);
         hs_on_o[i] <= !rst_i && hs_v[i][3];
         ls_on[i] <= !rst_i && ls_v[i][3];
      end
      shoot_o <= !rst_i && (shoot_o || |(hs_on_o & ls_on));
   end
endmodule : hbsgc_fet_model
`default_nettype wire

// ==== testbench/half_bridge_static_gate_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module half_bridge_static_gate_control_tb
   import hbsgc_pkg::*;
;
   logic clk = 0, rst = 1, en = 1, cs_n = 1, wr = 0, oc_en = 0, hsel = 0;
   hbsgc_cmd_type cmd = '0;
   hbsgc_fault_type flt = '0;
   logic [7:0] mapped = 8'h00;
   logic [31:0] st_code = 32'h0357_9BDF;
   logic [63:0] ccp_t = 64'h0908_0706_0504_0302;
   logic [63:0] blank_t = 64'h0101_0101_0101_0103;
   hbsgc_gate_type [NUM_HB-1:0] hs_g, ls_g;
   logic act, byp, exec, shoot;
   logic [15:0] modes_o;
   logic [7:0] hs_on;
   int err_total = 0, samples_checked = 0;

   always #2.5 clk = ~clk;

   hbsgc_top dut_u (.core_clk_i(clk), .rst_i(rst), .enable_i(en), .cs_n_i(cs_n), .cmd_wr_i(wr), .cmd_i(cmd),
      .faults_i(flt), .overcurrent_shutdown_enable_i(oc_en), .pwm_mapped_i(mapped),
      .static_gate_current_code_i(st_code), .cross_conduction_time_i(ccp_t),
      .drain_source_blank_time_i(blank_t), .drain_source_filter_time_i(8'h02), .high_side_o(hs_g),
      .low_side_o(ls_g), .drivers_active_o(act), .bridge_bypass_passive_o(byp), .half_bridge_mode_o(modes_o),
      .exec_o(exec));
   hbsgc_fet_model fet_u (.core_clk_i(clk), .rst_i(rst), .high_side_i(hs_g), .low_side_i(ls_g),
      .hs_on_o(hs_on), .shoot_o(shoot));

   // The verdict is printed in this one place only.
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Inputs move 1 ns after the edge so the design never samples a changing value.
   task tick;
      @(posedge clk);
      #1;
   endtask : tick

   function automatic hbsgc_gate_type g(input logic c, input hbsgc_src_type s, input logic [4:0] k);
      g = '{drive: 1'b1, charge: c, src: s, code: k};
   endfunction : g
   function automatic hbsgc_gate_type st(input int b, input logic c);
      st = g(c, CUR_STATIC, {1'b0, st_code[4*b +: 4]});
   endfunction : st
   function automatic hbsgc_gate_type hold(input logic c);
      hold = g(c, CUR_HOLD, hsel ? HOLD_HIGH_CODE : HOLD_LOW_CODE);
   endfunction : hold

   // One frame: decoded write under chip select, then the rising edge commits it.
   task send(input logic b, input logic h, input logic [15:0] m);
      int n;
      tick;
      cs_n = 0;
      wr = 1;
      cmd = '{b, h, m};
      tick;
      wr = 0;
      tick;
      cs_n = 1;
      n = 0;
      while (exec !== 1'b1 && n <= EXEC_MAX_CYC)
      begin
         tick;
         n++;
      end
      chk(32'(exec), 32'h1);
   endtask : send

   task phase(input int b, input hbsgc_gate_type hx, input hbsgc_gate_type lx, input int n);
      repeat (n)
      begin
         tick;
         chk(32'(hs_g[b]), 32'(hx));
         chk(32'(ls_g[b]), 32'(lx));
      end
   endtask : phase

   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst = 0;
      chk(32'(byp), 32'h1);
      chk(32'(modes_o), 32'h0);
      chk(32'(act), 32'h0);
      send(0, 0, 16'h0000);
      chk(32'(byp), 32'h0);
      repeat (2) tick;
      chk(32'(act), 32'h1);
      $display("test reset and activation done");
      // Bridge 0: off to high side, no cross-conduction phase; 5 cycles is blank 3 plus filter 2.
      send(0, 0, 16'h0002);
      phase(0, st(0, 1), g(0, CUR_HARD_OFF, HARD_OFF_CODE), 5);
      phase(0, hold(1), hold(0), 10);
      chk(32'(modes_o), 32'h2);
      chk(32'(hs_on[0]), 32'h1);
      // High side to low side runs the two-cycle cross-conduction phase first.
      send(0, 0, 16'h0001);
      phase(0, st(0, 0), st(0, 0), 2);
      phase(0, g(0, CUR_HARD_OFF, HARD_OFF_CODE), st(0, 1), 5);
      phase(0, hold(0), hold(1), 2);
      // Low side back to high side with the larger hold step.
      hsel = 1;
      send(0, 1, 16'h0002);
      phase(0, st(0, 0), st(0, 0), 2);
      phase(0, st(0, 1), g(0, CUR_HARD_OFF, HARD_OFF_CODE), 5);
      phase(0, hold(1), hold(0), 2);
      // Reserved code turns both off.
      send(0, 1, 16'h0003);
      phase(0, st(0, 0), st(0, 0), 2);
      phase(0, hold(0), hold(0), 2);
      $display("test sequences done");
      // A bridge owned by a PWM channel never switches on statically.
      mapped = 8'h02;
      send(0, 1, 16'h000B);
      repeat (12) tick;
      chk(32'(hs_g[1].charge), 32'h0);
      chk(32'(hs_on[1]), 32'h0);
      // Overcurrent is ignored until its shutdown enable is set, then it aborts bridge 2.
      flt.over_current = 1;
      send(0, 1, 16'h002B);
      phase(2, st(2, 1), g(0, CUR_HARD_OFF, HARD_OFF_CODE), 3);
      oc_en = 1;
      repeat (3) tick;
      chk(32'(hs_g[2]), 32'(st(2, 0)));
      flt.over_current = 0;
      oc_en = 0;
      flt.cp_uv = 1;
      repeat (3) tick;
      chk(32'(act), 32'h0);
      flt.cp_uv = 0;
      flt.fail_safe = 1;
      repeat (3) tick;
      chk(32'(act), 32'h0);
      chk(32'(hs_g[2].drive), 32'h0);
      flt.fail_safe = 0;
      repeat (3) tick;
      chk(32'(hs_g[2]), 32'(st(2, 0)));
      $display("test faults done");
      en = 0;
      repeat (3) tick;
      chk(32'(act), 32'h0);
      chk(32'(hs_g[0].drive), 32'h0);
      chk(32'(shoot), 32'h0);
      $display("test enable done");
      // Bypass set but one bridge switched on keeps the drivers active; all off makes them passive.
      en = 1;
      send(1, 0, 16'h0001);
      repeat (2) tick;
      chk(32'(act), 32'h1);
      send(1, 0, 16'h0000);
      repeat (2) tick;
      chk(32'(act), 32'h0);
      $display("test bypass modes done");
      complete_run;
   end
endmodule : half_bridge_static_gate_control_tb
`default_nettype wire
